// >>> ptc_cfg.svh
// Constants for the timer, counter and clear block.
// Assumes a 25 MHz system clock.
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
`define PTC_CLK_HZ         25000000
`define PTC_FAST_TICK_MS   1
`define PTC_SLOW_TICK_MS   100
`define PTC_MS_CYCLES      (`PTC_CLK_HZ / 1000)
`define PTC_FAST_CYCLES    (`PTC_MS_CYCLES * `PTC_FAST_TICK_MS)
`define PTC_SLOW_DIV       (`PTC_SLOW_TICK_MS / `PTC_FAST_TICK_MS)
`define PTC_NUM_TIMERS     2048
`define PTC_SUB_FIRST      1920
`define PTC_SUB_LAST       2047
`define PTC_VALUE_MAX      16'h7FFF
`define PTC_NUM_COUNTERS   16
`define PTC_NUM_SOURCES    2
`define PTC_NUM_WORDS      16
`define PTC_NUM_BITS       16
`endif

// >>> ptc_pkg.sv
// Types shared by the timer, counter and clear block.
// Constants live in ptc_cfg.svh.
package ptc_pkg;
    typedef logic [15:0] ptc_word_t;
    typedef enum logic [3:0] {
        PTC_CLR_BIT   = 4'h1,
        PTC_CLR_TIMER = 4'h2,
        PTC_CLR_CNT   = 4'h4,
        PTC_CLR_WORD  = 4'h8
    } ptc_clr_e;
    typedef struct packed {
        logic       valid;
        ptc_clr_e   kind;
        logic [10:0] index;
    } ptc_clr_s;
    typedef struct packed {
        logic       coil;
        logic       no_contact;
        logic       nc_contact;
        ptc_word_t  value;
    } ptc_elem_s;
endpackage

// >>> ptc_tick_gen.sv
// Time base divider producing 1 ms and 100 ms enable pulses.
// Runs on the single system clock.
`timescale 1ns/10ps
`include "ptc_cfg.svh"
module ptc_tick_gen (
    input  wire logic CLK_I,
    input  wire logic RST_I,
    output logic      fast_tick_o,
    output logic      slow_tick_o
);
    logic [14:0] ms_cnt_r;
    logic [6:0]  slow_cnt_r;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ms_cnt_r    <= 15'h0000;
            fast_tick_o <= 1'b0;
        end else if (ms_cnt_r == 15'(`PTC_FAST_CYCLES - 1)) begin
            ms_cnt_r    <= 15'h0000;
            fast_tick_o <= 1'b1;
        end else begin
            ms_cnt_r    <= ms_cnt_r + 15'h0001;
            fast_tick_o <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            slow_cnt_r  <= 7'h00;
            slow_tick_o <= 1'b0;
        end else if (ms_cnt_r == 15'(`PTC_FAST_CYCLES - 1)) begin
            if (slow_cnt_r == 7'(`PTC_SLOW_DIV - 1)) begin
                slow_cnt_r  <= 7'h00;
                slow_tick_o <= 1'b1;
            end else begin
                slow_cnt_r  <= slow_cnt_r + 7'h01;
                slow_tick_o <= 1'b0;
            end
        end else begin
            slow_tick_o <= 1'b0;
        end
    end
endmodule

// >>> ptc_core.sv
// Timer, counter, bit and word store with clear action.
// Assumes all inputs come from logic on CLK_I; one timer per module.
`timescale 1ns/10ps
`include "ptc_cfg.svh"
module ptc_core
    import ptc_pkg::*;
(
    input  wire logic                        CLK_I,
    input  wire logic                        RST_I,
    input  wire logic [10:0]                 TMR_INDEX_I,
    input  wire logic [`PTC_NUM_SOURCES-1:0] TMR_EN_I,
    input  wire logic [`PTC_NUM_SOURCES-1:0] TMR_FAST_I,
    input  wire ptc_word_t [`PTC_NUM_SOURCES-1:0] TMR_PRESET_I,
    input  wire logic                        TMR_ACCUM_I,
    input  wire logic [3:0]                  CNT_INDEX_I,
    input  wire logic                        CNT_EXEC_I,
    input  wire ptc_word_t                   CNT_PRESET_I,
    input  wire ptc_clr_s                    CLR_I,
    input  wire logic                        BIT_SET_I,
    input  wire logic [3:0]                  BIT_INDEX_I,
    input  wire logic                        WORD_WR_I,
    input  wire logic [3:0]                  WORD_INDEX_I,
    input  wire ptc_word_t                   WORD_DATA_I,
    output ptc_elem_s                        TMR_STATE_O,
    output logic                             TMR_SUB_O,
    output ptc_elem_s                        CNT_STATE_O,
    output logic [`PTC_NUM_BITS-1:0]         BITS_O,
    output ptc_word_t                        WORD_O
);
    typedef enum logic [2:0] {
        PTC_T_IDLE = 3'b001,
        PTC_T_RUN  = 3'b010,
        PTC_T_DONE = 3'b100
    } ptc_tstate_e;

    ptc_tstate_e tstate_r;
    ptc_tstate_e tstate_nxt;
    logic        fast_tick;
    logic        slow_tick;
    logic        all_en;
    logic        tick;
    logic        hit;
    logic        clr_tmr;
    logic        clr_cnt;
    ptc_word_t   tval_r;
    ptc_word_t   tval_nxt;
    ptc_word_t   cval_r [`PTC_NUM_COUNTERS];
    logic [`PTC_NUM_COUNTERS-1:0] cdone_r;
    logic [`PTC_NUM_COUNTERS-1:0] ccoil_r;
    ptc_word_t   words_r [`PTC_NUM_WORDS];
    logic [`PTC_NUM_BITS-1:0] bits_r;
    logic [3:0]  cnt_sel_r;
    logic [3:0]  word_sel_r;

    ptc_tick_gen u_tick (
        .CLK_I       (CLK_I),
        .RST_I       (RST_I),
        .fast_tick_o (fast_tick),
        .slow_tick_o (slow_tick)
    );

    // Timer enabled only while every driving condition is on
    assign all_en  = &TMR_EN_I;
    assign clr_tmr = CLR_I.valid && CLR_I.kind == PTC_CLR_TIMER
                     && CLR_I.index == TMR_INDEX_I;
    assign clr_cnt = CLR_I.valid && CLR_I.kind == PTC_CLR_CNT;
    assign tick    = (|TMR_FAST_I) ? fast_tick : slow_tick;

    // First preset the count reaches is the one that counts
    always_comb begin
        hit = 1'b0;
        for (int i = 0; i < `PTC_NUM_SOURCES; i++) begin
            if (tval_r >= TMR_PRESET_I[i]) begin
                hit = 1'b1;
            end
        end
    end

    always_comb begin
        tstate_nxt = tstate_r;
        tval_nxt   = tval_r;
        unique case (tstate_r)
            PTC_T_IDLE: begin
                if (all_en) begin
                    tstate_nxt = PTC_T_RUN;
                end
            end
            PTC_T_RUN: begin
                if (!all_en) begin
                    tstate_nxt = PTC_T_IDLE;
                    tval_nxt   = TMR_ACCUM_I ? tval_r : 16'h0000;
                end else if (hit) begin
                    tstate_nxt = PTC_T_DONE;
                end else if (tick && tval_r < `PTC_VALUE_MAX) begin
                    tval_nxt = tval_r + 16'h0001;
                end
            end
            PTC_T_DONE: begin
                if (!all_en) begin
                    tstate_nxt = PTC_T_IDLE;
                    tval_nxt   = TMR_ACCUM_I ? tval_r : 16'h0000;
                end else if (!hit) begin
                    tstate_nxt = PTC_T_RUN;
                    tval_nxt   = 16'h0000;
                end
            end
        endcase
        if (clr_tmr) begin
            tstate_nxt = PTC_T_IDLE;
            tval_nxt   = 16'h0000;
        end
    end

    // Value held at preset while enabled
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tstate_r <= PTC_T_IDLE;
            tval_r   <= 16'h0000;
        end else begin
            tstate_r <= tstate_nxt;
            tval_r   <= tval_nxt;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            TMR_STATE_O <= '{coil: 1'b0, no_contact: 1'b0, nc_contact: 1'b1, value: 16'h0000};
            TMR_SUB_O   <= 1'b0;
        end else begin
            TMR_STATE_O.coil       <= all_en && !clr_tmr;
            TMR_STATE_O.no_contact <= tstate_nxt == PTC_T_DONE;
            TMR_STATE_O.nc_contact <= tstate_nxt != PTC_T_DONE;
            TMR_STATE_O.value      <= tval_nxt;
            TMR_SUB_O <= TMR_INDEX_I >= 11'(`PTC_SUB_FIRST);
        end
    end

    // Counters, one per index
    for (genvar g = 0; g < `PTC_NUM_COUNTERS; g++) begin : g_cnt
        always_ff @(posedge CLK_I or posedge RST_I) begin
            if (RST_I) begin
                cval_r[g]  <= 16'h0000;
                cdone_r[g] <= 1'b0;
                ccoil_r[g] <= 1'b0;
            end else if (clr_cnt && CLR_I.index[3:0] == 4'(g)) begin
                cval_r[g]  <= 16'h0000;
                cdone_r[g] <= 1'b0;
                ccoil_r[g] <= 1'b0;
            end else if (CNT_EXEC_I && CNT_INDEX_I == 4'(g)) begin
                ccoil_r[g] <= 1'b1;
                if (!cdone_r[g]) begin
                    if (cval_r[g] + 16'h0001 >= CNT_PRESET_I) begin
                        cdone_r[g] <= 1'b1;
                    end
                    cval_r[g] <= cval_r[g] + 16'h0001;
                end
            end
        end
    end

    // Bits and words with clear
    for (genvar b = 0; b < `PTC_NUM_BITS; b++) begin : g_bit
        always_ff @(posedge CLK_I or posedge RST_I) begin
            if (RST_I) begin
                bits_r[b] <= 1'b0;
            end else if (CLR_I.valid && CLR_I.kind == PTC_CLR_BIT
                         && CLR_I.index[3:0] == 4'(b)) begin
                bits_r[b] <= 1'b0;
            end else if (BIT_SET_I && BIT_INDEX_I == 4'(b)) begin
                bits_r[b] <= 1'b1;
            end
        end
    end

    for (genvar w = 0; w < `PTC_NUM_WORDS; w++) begin : g_word
        always_ff @(posedge CLK_I or posedge RST_I) begin
            if (RST_I) begin
                words_r[w] <= 16'h0000;
            end else if (CLR_I.valid && CLR_I.kind == PTC_CLR_WORD
                         && CLR_I.index[3:0] == 4'(w)) begin
                words_r[w] <= 16'h0000;
            end else if (WORD_WR_I && WORD_INDEX_I == 4'(w)) begin
                words_r[w] <= WORD_DATA_I;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt_sel_r  <= 4'h0;
            word_sel_r <= 4'h0;
        end else begin
            cnt_sel_r  <= CNT_INDEX_I;
            word_sel_r <= WORD_INDEX_I;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CNT_STATE_O <= '{coil: 1'b0, no_contact: 1'b0, nc_contact: 1'b1, value: 16'h0000};
            BITS_O      <= '0;
            WORD_O      <= 16'h0000;
        end else begin
            CNT_STATE_O.coil       <= ccoil_r[cnt_sel_r];
            CNT_STATE_O.no_contact <= cdone_r[cnt_sel_r];
            CNT_STATE_O.nc_contact <= !cdone_r[cnt_sel_r];
            CNT_STATE_O.value      <= cval_r[cnt_sel_r];
            BITS_O                 <= bits_r;
            WORD_O                 <= words_r[word_sel_r];
        end
    end
endmodule

// >>> ptc_core_chk.sv
// Port checker for ptc_core, attached by the bind at the foot.
// Assumes one clock CLK_I and the asynchronous reset RST_I.
`timescale 1ns/10ps
`include "ptc_cfg.svh"
module ptc_core_chk
    import ptc_pkg::*;
(
    input wire logic [0:0]                  CLK_I,
    input wire logic [0:0]                  RST_I,
    input wire logic [10:0]                 TMR_INDEX_I,
    input wire logic [`PTC_NUM_SOURCES-1:0] TMR_EN_I,
    input wire logic [3:0]                  CNT_INDEX_I,
    input wire ptc_clr_s                    CLR_I,
    input wire logic                        WORD_WR_I,
    input wire logic [3:0]                  WORD_INDEX_I,
    input wire ptc_elem_s                   TMR_STATE_O,
    input wire logic                        TMR_SUB_O,
    input wire ptc_elem_s                   CNT_STATE_O,
    input wire ptc_word_t                   WORD_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_cnt_quiet;
        CNT_STATE_O.no_contact && !CLR_I.valid && $stable(CNT_INDEX_I);
    endsequence
    sequence s_word_clr;
        CLR_I.valid && CLR_I.kind == PTC_CLR_WORD && CLR_I.index[3:0] == WORD_INDEX_I
            ##1 $stable(WORD_INDEX_I) && !WORD_WR_I;
    endsequence
    AST_SUB_FLAG: assert property (TMR_SUB_O == ($past(TMR_INDEX_I) >= 11'h780))
        else $error("reserved timer flag wrong");
    AST_CNT_CONTACTS: assert property (CNT_STATE_O.nc_contact == !CNT_STATE_O.no_contact)
        else $error("counter contacts not complementary");
    AST_TMR_CONTACTS: assert property (TMR_STATE_O.nc_contact == !TMR_STATE_O.no_contact)
        else $error("timer contacts not complementary");
    AST_TMR_COIL: assert property ((&TMR_EN_I) && !CLR_I.valid |=> TMR_STATE_O.coil)
        else $error("timer coil not energised");
    AST_TMR_OFF: assert property (!(&TMR_EN_I) |=> !TMR_STATE_O.coil && !TMR_STATE_O.no_contact)
        else $error("timer not held off");
    AST_TMR_STEP: assert property (!$stable(TMR_STATE_O.value) && TMR_STATE_O.value != 16'h0000
        |-> TMR_STATE_O.value == $past(TMR_STATE_O.value) + 16'h0001) else $error("timer step wrong");
    AST_TMR_HOLD: assert property (TMR_STATE_O.no_contact && (&TMR_EN_I) && !CLR_I.valid
        |=> $stable(TMR_STATE_O.value)) else $error("timer moved past preset");
    AST_TMR_CLR: assert property (CLR_I.valid && CLR_I.kind == PTC_CLR_TIMER
        && CLR_I.index == TMR_INDEX_I |=> TMR_STATE_O.value == 16'h0000 && !TMR_STATE_O.no_contact)
        else $error("timer clear failed");
    AST_CNT_FROZEN: assert property (s_cnt_quiet [*2] |=> $stable(CNT_STATE_O.value))
        else $error("matched counter moved");
    AST_WORD_CLR: assert property (s_word_clr |=> WORD_O == 16'h0000)
        else $error("word clear failed");
endmodule
bind ptc_core ptc_core_chk ptc_core_chk_i (.*);

// >>> ptc_core_bench.sv
// Self-checking bench for ptc_core: words, bits, counter, timer.
// Needs ptc_pkg, ptc_core and ptc_core_chk compiled first.
`timescale 1ns/10ps
module ptc_core_bench
    import ptc_pkg::*;
();
    typedef struct packed {logic [2:0] sel; ptc_word_t v;} ptc_note_s;
    logic            CLK_I = 1'b0, RST_I = 1'b1, TMR_ACCUM_I = 1'b0, CNT_EXEC_I = 1'b0;
    logic            BIT_SET_I = 1'b0, WORD_WR_I = 1'b0, due = 1'b0, TMR_SUB_O;
    logic [1:0]      TMR_EN_I = 2'h0, TMR_FAST_I = 2'h0;
    logic [3:0]      CNT_INDEX_I = 4'h0, BIT_INDEX_I = 4'h0, WORD_INDEX_I = 4'h0;
    logic [10:0]     TMR_INDEX_I = 11'h005;
    logic [15:0]     BITS_O;
    ptc_word_t [1:0] TMR_PRESET_I = '0;
    ptc_word_t       CNT_PRESET_I = 16'h0000, WORD_DATA_I = 16'h0000, WORD_O, p;
    ptc_word_t       wd [4];
    ptc_clr_s        CLR_I = '0;
    ptc_elem_s       TMR_STATE_O, CNT_STATE_O;
    ptc_note_s       q [$];
    ptc_note_s       n;
    int              error_cnt = 0, n_compared = 0, r;

    ptc_core ptc_core_i (.*);
    initial forever #20 CLK_I = ~CLK_I;

    task automatic tk(input int c);
        repeat (c) @(posedge CLK_I);
    endtask
    task automatic cmp(input ptc_word_t s, input ptc_word_t e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic see(input logic [2:0] s, input ptc_word_t v);
        q.push_back({s, v});
        due <= 1'b1;
        tk(1);
        due <= 1'b0;
        tk(1);
    endtask
    task automatic clr(input ptc_clr_e k, input logic [10:0] i, input logic w);
        tk(1);
        CLR_I <= {1'b1, k, i};
        WORD_WR_I <= w;
        tk(1);
        CLR_I.valid <= 1'b0;
        WORD_WR_I <= 1'b0;
    endtask
    task automatic wt(input ptc_word_t v);
        for (int k = 0; k < 30000 && TMR_STATE_O.value !== v; k++) tk(1);
    endtask
    task automatic final_report();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge CLK_I) begin
        if (due) begin
            n = q.pop_front();
            case (n.sel)
                3'h0: cmp(WORD_O, n.v);
                3'h1: cmp(CNT_STATE_O.value, n.v);
                3'h2: cmp({15'h0000, CNT_STATE_O.no_contact}, n.v);
                3'h3: cmp(BITS_O, n.v);
                3'h4: cmp(TMR_STATE_O.value, n.v);
                3'h5: cmp({15'h0000, TMR_STATE_O.no_contact}, n.v);
                default: cmp({15'h0000, TMR_SUB_O}, n.v);
            endcase
        end
    end

    initial begin
        tk(90000);
        error_cnt++;
        final_report();
    end

    initial begin
        r = $urandom(1);
        tk(12);
        RST_I <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wd[i] = ptc_word_t'($urandom);
            WORD_WR_I <= 1'b1;
            WORD_INDEX_I <= i[3:0];
            WORD_DATA_I <= wd[i];
            tk(1);
        end
        WORD_WR_I <= 1'b0;
        clr(PTC_CLR_WORD, 11'h001, 1'b0);
        clr(PTC_CLR_WORD, 11'h003, 1'b1);
        for (int i = 0; i < 4; i++) begin
            WORD_INDEX_I <= i[3:0];
            tk(3);
            see(3'h0, i[0] ? 16'h0000 : wd[i]);
        end
        BIT_SET_I <= 1'b1;
        BIT_INDEX_I <= 4'h3;
        tk(1);
        BIT_INDEX_I <= 4'h9;
        tk(1);
        BIT_SET_I <= 1'b0;
        clr(PTC_CLR_BIT, 11'h003, 1'b0);
        tk(3);
        see(3'h3, 16'h0200);
        p = 16'h0003 + ptc_word_t'($urandom % 4);
        CNT_INDEX_I <= 4'h2;
        CNT_PRESET_I <= p;
        repeat (p + 3) begin
            tk(1);
            CNT_EXEC_I <= 1'b1;
            tk(1);
            CNT_EXEC_I <= 1'b0;
        end
        tk(3);
        see(3'h1, p);
        see(3'h2, 16'h0001);
        clr(PTC_CLR_CNT, 11'h002, 1'b0);
        tk(3);
        see(3'h1, 16'h0000);
        TMR_INDEX_I <= 11'h780;
        tk(3);
        see(3'h6, 16'h0001);
        TMR_INDEX_I <= 11'h005;
        TMR_FAST_I <= 2'b11;
        TMR_PRESET_I <= {16'h0002, 16'h0001};
        TMR_EN_I <= 2'b11;
        wt(16'h0001);
        tk(100);
        see(3'h4, 16'h0001);
        see(3'h5, 16'h0001);
        TMR_EN_I <= 2'b10;
        tk(2);
        see(3'h4, 16'h0000);
        see(3'h5, 16'h0000);
        TMR_ACCUM_I <= 1'b1;
        TMR_PRESET_I <= {16'h0003, 16'h0003};
        TMR_EN_I <= 2'b11;
        wt(16'h0001);
        TMR_EN_I <= 2'b01;
        tk(2);
        see(3'h4, 16'h0001);
        TMR_EN_I <= 2'b11;
        wt(16'h0002);
        see(3'h4, 16'h0002);
        clr(PTC_CLR_TIMER, 11'h005, 1'b0);
        see(3'h4, 16'h0000);
        final_report();
    end
endmodule
